// ==== src/iec_pkg.sv ====
// Constants, register map and types of the interrupt and event transfer block.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
package iec_pkg;
    localparam int NUM_SRC = 24;
    localparam int NUM_CH = 8;
    localparam int NUM_HWT = 4;
    // Trap numbers; a vector location is four times the trap number
    localparam logic [6:0] TRAPNUM_SRC0 = 7'h10;
    localparam logic [6:0] TRAPNUM_NMI = 7'h02;
    localparam logic [6:0] TRAPNUM_STKOF = 7'h04;
    localparam logic [6:0] TRAPNUM_STKUF = 7'h06;
    localparam logic [6:0] TRAPNUM_CLASSB = 7'h0A;
    // Response time window and its cycle counts at the system clock
    localparam int CLK_PERIOD_PS = 10000;
    localparam int RESP_MIN_PS = 250000;
    localparam int RESP_MAX_PS = 600000;
    localparam int RESP_MIN_CYC = (RESP_MIN_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int RESP_MAX_CYC = RESP_MAX_PS / CLK_PERIOD_PS;
    // Register byte offsets
    localparam logic [11:0] OFS_SRC_CTRL = 12'h000;
    localparam logic [11:0] OFS_CH_BASE = 12'h080;
    localparam logic [11:0] OFS_TRAP_FLAGS = 12'h100;
    localparam logic [11:0] OFS_STATUS = 12'h104;
    localparam logic [11:0] OFS_MASK = 12'h108;
    localparam int CH_STRIDE = 16;
    localparam logic [3:0] CH_OFS_CTRL = 4'h0;
    localparam logic [3:0] CH_OFS_SRC = 4'h4;
    localparam logic [3:0] CH_OFS_DST = 4'h8;
    // Source control fields
    localparam int SC_LVL_LSB = 0;
    localparam int SC_EN_BIT = 6;
    localparam int SC_REQ_BIT = 7;
    localparam int SC_XFER_BIT = 8;
    localparam int SC_CH_LSB = 9;
    // Channel control fields
    localparam int CC_CNT_LSB = 0;
    localparam int CC_WORD_BIT = 8;
    localparam int CC_INCDST_BIT = 9;
    localparam int CC_CONT_BIT = 10;
    // Status and mask bits
    localparam int ST_CNT_ZERO = 0;
    localparam int ST_TRAP = 1;
    localparam int ST_W = 2;
    // Reset values and the hardware trap level
    localparam logic [11:0] SRC_CTRL_RST = 12'h000;
    localparam logic [10:0] CH_CTRL_RST = 11'h000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [3:0] LVL_TRAP = 4'hF;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic word;
    } iec_xfer_t;

    typedef struct packed {
        logic req;
        logic [8:0] vec;
        logic [3:0] lvl;
    } iec_int_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_REQ} iec_state_t;
endpackage : iec_pkg

// ==== src/iec_ctrl.sv ====
// Interrupt controller with eight-channel single-cycle event transfer engine.
// Assumes peripherals give one-cycle request pulses and the CPU pulses
// cpu_ack_i when it takes the vector on int_o.
//
// Behaviour
// - Each source is set by its control word to vectored or transfer service.
// - A transfer takes one cycle and issues no vector.
// - A transfer moves a byte or word and bumps the source or dest pointer.
// - Each channel counter drops by one per transfer unless continuous.
// - A counter at zero turns the source's next service into its vector.
// - Eight independent transfer channels exist.
// - Each source has a control word with request, enable and level.
// - The level field chooses one of sixteen priorities.
// - Only a source at a strictly higher level than the running one is served.
// - A vectored service presents the source's own vector to the CPU.
// - Vector is four times the trap number, sources at 10h to 27h.
// - A software trap with its number uses the same vector scheme.
// - Request to vector takes 250 ns to 600 ns.
// - Hardware traps skip masking, set a trap flag, and block source service.
`timescale 1ns/1ps
module iec_ctrl
    import iec_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_SRC-1:0] src_req_i,
    input wire logic [NUM_HWT-1:0] hw_trap_i,
    input wire logic sw_trap_i,
    input wire logic [6:0] sw_trap_num_i,
    input wire logic [3:0] cpu_lvl_i,
    input wire logic cpu_ack_i,
    output iec_int_t int_o,
    output logic xfer_valid_o,
    output iec_xfer_t xfer_o,
    output logic irq_o
);
    logic [11:0] src_ctrl [NUM_SRC];
    logic [11:0] next_src_ctrl [NUM_SRC];
    logic [10:0] ch_ctrl [NUM_CH];
    logic [10:0] next_ch_ctrl [NUM_CH];
    logic [15:0] ch_src [NUM_CH];
    logic [15:0] next_ch_src [NUM_CH];
    logic [15:0] ch_dst [NUM_CH];
    logic [15:0] next_ch_dst [NUM_CH];
    logic [NUM_HWT-1:0] trap_flags, next_trap_flags;
    logic [NUM_HWT-1:0] trap_pend, next_trap_pend;
    logic sw_pend, next_sw_pend;
    logic [6:0] sw_num, next_sw_num;
    logic [ST_W-1:0] status, next_status;
    logic [ST_W-1:0] mask, next_mask;
    iec_state_t state, next_state;
    logic [7:0] wait_cnt, next_wait_cnt;
    logic [4:0] cur_src, next_cur_src;
    logic cur_is_src, next_cur_is_src;
    iec_int_t next_int;
    logic next_xfer_valid;
    iec_xfer_t next_xfer;
    logic next_irq;
    logic [31:0] next_wb_dat;
    logic next_wb_ack;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : merge

    function automatic logic [8:0] vec_of(input logic [6:0] num);
        return {num, 2'b00};
    endfunction : vec_of

    function automatic logic [6:0] hwt_num(input int idx);
        case (idx)
            0: return TRAPNUM_NMI;
            1: return TRAPNUM_STKOF;
            2: return TRAPNUM_STKUF;
            default: return TRAPNUM_CLASSB;
        endcase
    endfunction : hwt_num

    // Arbitration over all pending, enabled sources
    logic win_found;
    logic [4:0] win_idx;
    logic [3:0] win_lvl;
    always_comb
    begin
        win_found = 1'b0;
        win_idx = 5'd0;
        win_lvl = 4'h0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (src_ctrl[i][SC_REQ_BIT] && src_ctrl[i][SC_EN_BIT] &&
                (!win_found ||
                 src_ctrl[i][SC_LVL_LSB +: 4] > win_lvl))
            begin
                win_found = 1'b1;
                win_idx = 5'(i);
                win_lvl = src_ctrl[i][SC_LVL_LSB +: 4];
            end
        end
    end

    logic [2:0] win_ch;
    logic win_xfer;
    logic win_cont;
    logic [7:0] win_cnt;
    assign win_ch = src_ctrl[win_idx][SC_CH_LSB +: 3];
    assign win_cont = ch_ctrl[win_ch][CC_CONT_BIT];
    assign win_cnt = ch_ctrl[win_ch][CC_CNT_LSB +: 8];
    assign win_xfer = src_ctrl[win_idx][SC_XFER_BIT] &&
        (win_cont || win_cnt != 8'h00);

    logic wb_req;
    logic [9:0] word_adr;
    logic [4:0] ch_sel;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign word_adr = wb_adr_i[11:2];
    assign ch_sel = 5'(wb_adr_i[11:4] - OFS_CH_BASE[11:4]);

    always_comb
    begin
        logic hit_src;
        logic hit_ch;
        logic [7:0] dec;
        logic [15:0] step;
        hit_src = 1'b0;
        hit_ch = 1'b0;
        dec = 8'h00;
        step = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++)
            next_src_ctrl[i] = src_ctrl[i];
        for (int c = 0; c < NUM_CH; c++)
        begin
            next_ch_ctrl[c] = ch_ctrl[c];
            next_ch_src[c] = ch_src[c];
            next_ch_dst[c] = ch_dst[c];
        end
        next_trap_flags = trap_flags;
        next_trap_pend = trap_pend;
        next_sw_pend = sw_pend;
        next_sw_num = sw_num;
        next_status = status;
        next_mask = mask;
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_cur_src = cur_src;
        next_cur_is_src = cur_is_src;
        next_int = int_o;
        next_xfer_valid = 1'b0;
        next_xfer = xfer_o;
        next_wb_ack = wb_req;
        next_wb_dat = 32'h0000_0000;

        // Register bus: reads and software writes
        if (wb_req)
        begin
            hit_src = wb_adr_i < OFS_SRC_CTRL + 12'(NUM_SRC * 4);
            hit_ch = wb_adr_i >= OFS_CH_BASE &&
                wb_adr_i < OFS_CH_BASE + 12'(NUM_CH * CH_STRIDE);
            if (hit_src)
            begin
                next_wb_dat = {20'h0_0000, src_ctrl[word_adr[4:0]]};
                if (wb_we_i)
                    next_src_ctrl[word_adr[4:0]] = 12'(merge(
                        32'(src_ctrl[word_adr[4:0]]), wb_dat_i,
                        wb_sel_i));
            end
            else if (hit_ch)
            begin
                case (wb_adr_i[3:0])
                    CH_OFS_CTRL:
                    begin
                        next_wb_dat = 32'(ch_ctrl[ch_sel[2:0]]);
                        if (wb_we_i)
                            next_ch_ctrl[ch_sel[2:0]] = 11'(merge(
                                32'(ch_ctrl[ch_sel[2:0]]), wb_dat_i,
                                wb_sel_i));
                    end
                    CH_OFS_SRC:
                    begin
                        next_wb_dat = 32'(ch_src[ch_sel[2:0]]);
                        if (wb_we_i)
                            next_ch_src[ch_sel[2:0]] = 16'(merge(
                                32'(ch_src[ch_sel[2:0]]), wb_dat_i,
                                wb_sel_i));
                    end
                    CH_OFS_DST:
                    begin
                        next_wb_dat = 32'(ch_dst[ch_sel[2:0]]);
                        if (wb_we_i)
                            next_ch_dst[ch_sel[2:0]] = 16'(merge(
                                32'(ch_dst[ch_sel[2:0]]), wb_dat_i,
                                wb_sel_i));
                    end
                    default: next_wb_dat = 32'h0000_0000;
                endcase
            end
            else if (wb_adr_i == OFS_TRAP_FLAGS)
            begin
                next_wb_dat = 32'(trap_flags);
                if (wb_we_i && wb_sel_i[0])
                    next_trap_flags = trap_flags & ~wb_dat_i[NUM_HWT-1:0];
            end
            else if (wb_adr_i == OFS_STATUS)
            begin
                next_wb_dat = 32'(status);
                if (wb_we_i && wb_sel_i[0])
                    next_status = status & ~wb_dat_i[ST_W-1:0];
            end
            else if (wb_adr_i == OFS_MASK)
            begin
                next_wb_dat = 32'(mask);
                if (wb_we_i && wb_sel_i[0])
                    next_mask = wb_dat_i[ST_W-1:0];
            end
        end

        // Service sequencing
        case (state)
            ST_IDLE:
            begin
                if (|trap_pend)
                begin
                    for (int t = NUM_HWT - 1; t >= 0; t--)
                        if (trap_pend[t])
                        begin
                            next_int.vec = vec_of(hwt_num(t));
                            next_cur_src = 5'(t);
                        end
                    next_int.lvl = LVL_TRAP;
                    next_cur_is_src = 1'b0;
                    next_wait_cnt = 8'h00;
                    next_state = ST_WAIT;
                end
                else if (sw_pend)
                begin
                    next_int.vec = vec_of(sw_num);
                    next_int.lvl = cpu_lvl_i;
                    next_cur_src = 5'h10;
                    next_cur_is_src = 1'b0;
                    next_wait_cnt = 8'h00;
                    next_state = ST_WAIT;
                end
                else if (win_found && !(|trap_flags) &&
                    win_lvl > cpu_lvl_i)
                begin
                    if (win_xfer)
                    begin
                        step = ch_ctrl[win_ch][CC_WORD_BIT] ? 16'h0002
                            : 16'h0001;
                        next_xfer_valid = 1'b1;
                        next_xfer.src = ch_src[win_ch];
                        next_xfer.dst = ch_dst[win_ch];
                        next_xfer.word = ch_ctrl[win_ch][CC_WORD_BIT];
                        if (ch_ctrl[win_ch][CC_INCDST_BIT])
                            next_ch_dst[win_ch] = ch_dst[win_ch] + step;
                        else
                            next_ch_src[win_ch] = ch_src[win_ch] + step;
                        if (!win_cont)
                        begin
                            dec = win_cnt - 8'h01;
                            next_ch_ctrl[win_ch][CC_CNT_LSB +: 8] = dec;
                        end
                        // flag stays set when the count runs out
                        if (win_cont || dec != 8'h00)
                            next_src_ctrl[win_idx][SC_REQ_BIT] = 1'b0;
                        else
                            next_status[ST_CNT_ZERO] = 1'b1;
                    end
                    else
                    begin
                        next_int.vec = vec_of(TRAPNUM_SRC0 +
                            7'(win_idx));
                        next_int.lvl = win_lvl;
                        next_cur_src = win_idx;
                        next_cur_is_src = 1'b1;
                        next_wait_cnt = 8'h00;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                next_wait_cnt = wait_cnt + 8'h01;
                if (wait_cnt == 8'(RESP_MIN_CYC - 2))
                begin
                    next_int.req = 1'b1;
                    next_state = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (cpu_ack_i)
                begin
                    next_int.req = 1'b0;
                    next_state = ST_IDLE;
                    if (cur_is_src)
                        next_src_ctrl[cur_src][SC_REQ_BIT] = 1'b0;
                    else if (cur_src[4])
                        next_sw_pend = 1'b0;
                    else
                        next_trap_pend[cur_src[1:0]] = 1'b0;
                end
            end
            default: next_state = ST_IDLE;
        endcase

        // Hardware events win over clears in the same cycle
        for (int i = 0; i < NUM_SRC; i++)
            if (src_req_i[i])
                next_src_ctrl[i][SC_REQ_BIT] = 1'b1;
        if (|hw_trap_i)
        begin
            next_trap_flags = next_trap_flags | hw_trap_i;
            next_trap_pend = next_trap_pend | hw_trap_i;
            next_status[ST_TRAP] = 1'b1;
        end
        if (sw_trap_i && !sw_pend)
        begin
            next_sw_pend = 1'b1;
            next_sw_num = sw_trap_num_i;
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < NUM_SRC; i++)
                src_ctrl[i] <= SRC_CTRL_RST;
            for (int c = 0; c < NUM_CH; c++)
            begin
                ch_ctrl[c] <= CH_CTRL_RST;
                ch_src[c] <= PTR_RST;
                ch_dst[c] <= PTR_RST;
            end
            trap_flags <= '0;
            trap_pend <= '0;
            sw_pend <= 1'b0;
            sw_num <= 7'h00;
            status <= '0;
            mask <= '0;
            state <= ST_IDLE;
            wait_cnt <= 8'h00;
            cur_src <= 5'h00;
            cur_is_src <= 1'b0;
            int_o <= '0;
            xfer_valid_o <= 1'b0;
            xfer_o <= '0;
            irq_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            src_ctrl <= next_src_ctrl;
            ch_ctrl <= next_ch_ctrl;
            ch_src <= next_ch_src;
            ch_dst <= next_ch_dst;
            trap_flags <= next_trap_flags;
            trap_pend <= next_trap_pend;
            sw_pend <= next_sw_pend;
            sw_num <= next_sw_num;
            status <= next_status;
            mask <= next_mask;
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            cur_src <= next_cur_src;
            cur_is_src <= next_cur_is_src;
            int_o <= next_int;
            xfer_valid_o <= next_xfer_valid;
            xfer_o <= next_xfer;
            irq_o <= next_irq;
            wb_dat_o <= next_wb_dat;
            wb_ack_o <= next_wb_ack;
        end
    end
endmodule : iec_ctrl

// ==== verification/iec_cpu_model.sv ====
// CPU model: takes each vector and runs its service at the vector's level.
// Assumes the int_o carrier and one system clock.
`timescale 1ns/1ps
module iec_cpu_model
    import iec_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input iec_int_t int_i,
    input wire logic [7:0] ack_dly_i,
    input wire logic [7:0] svc_len_i,
    output logic cpu_ack_o,
    output logic [3:0] cpu_lvl_o
);
    logic [7:0] cnt;
    logic [7:0] svc;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt <= 8'h00;
            svc <= 8'h00;
            cpu_ack_o <= 1'b0;
            cpu_lvl_o <= 4'h0;
        end
        else
        begin
            cpu_ack_o <= 1'b0;
            if (cpu_ack_o)
            begin
                cpu_lvl_o <= int_i.lvl;
                svc <= svc_len_i;
            end
            else if (int_i.req)
            begin
                cnt <= (cnt == ack_dly_i) ? 8'h00 : cnt + 8'h01;
                cpu_ack_o <= (cnt == ack_dly_i);
            end
            else if (svc != 8'h00)
            begin
                svc <= svc - 8'h01;
                if (svc == 8'h01)
                    cpu_lvl_o <= 4'h0;
            end
        end
    end
endmodule : iec_cpu_model

// ==== verification/iec_ctrl_properties.sv ====
// Checker on the controller's ports, bound into every instance.
// Assumes one clock and an active low asynchronous reset.
`timescale 1ns/1ps
module iec_ctrl_properties
    import iec_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_HWT-1:0] hw_trap_i,
    input wire logic [3:0] cpu_lvl_i,
    input wire logic cpu_ack_i,
    input iec_int_t int_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic [7:0] low_cnt;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            low_cnt <= 8'h00;
        else if (int_o.req)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF)
            low_cnt <= low_cnt + 8'h01;
    end
    a_bus_answer: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_vector_aligned: assert property
        (int_o.req |-> int_o.vec[1:0] == 2'b00)
        else $error("vector not four times trap number");
    a_vector_holds: assert property
        (int_o.req && !cpu_ack_i |=> int_o.req && $stable(int_o.vec))
        else $error("vector dropped before ack");
    a_vector_release: assert property
        (int_o.req && cpu_ack_i |=> !int_o.req)
        else $error("vector stays after ack");
    a_response_min: assert property
        ($rose(int_o.req) |-> low_cnt >= 8'(RESP_MIN_CYC - 1))
        else $error("vector too early");
    a_level_above: assert property
        (int_o.req && int_o.vec >= 9'h040 && int_o.vec <= 9'h09C
        |-> int_o.lvl > cpu_lvl_i)
        else $error("source served at or below cpu level");
    a_nmi_served: assert property
        (hw_trap_i[0] |-> ##[1:200] (int_o.req && int_o.vec == 9'h008))
        else $error("nmi not served");
endmodule : iec_ctrl_properties
bind iec_ctrl iec_ctrl_properties i_props (.ref_clk_i, .rst_b_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .hw_trap_i,
    .cpu_lvl_i, .cpu_ack_i, .int_o);

// ==== verification/testbench.sv ====
// Self-checking bench: Wishbone tasks, request pulses, CPU model.
// Assumes the controller and model share one 100 MHz clock.
`timescale 1ns/1ps
module testbench
    import iec_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0, hw_trap = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd, cw;
    logic [NUM_SRC-1:0] src_req = '0;
    logic sw_trap = 1'b0, ack, xv, irq, cpu_ack;
    logic [6:0] sw_num = 7'h00;
    logic [3:0] cpu_lvl;
    logic [7:0] ack_dly = 8'h00, svc_len = 8'h02;
    logic [6:0] tn [4] = '{TRAPNUM_NMI, TRAPNUM_STKOF, TRAPNUM_STKUF,
        TRAPNUM_CLASSB};
    iec_int_t intr;
    iec_xfer_t xf;
    int n_fail = 0, num_checks = 0, cyc_n = 0, t0 = 0, lat = 0, st = 0;
    always #5 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;
    iec_ctrl i_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .src_req_i(src_req), .hw_trap_i(hw_trap), .sw_trap_i(sw_trap),
        .sw_trap_num_i(sw_num), .cpu_lvl_i(cpu_lvl), .cpu_ack_i(cpu_ack),
        .int_o(intr), .xfer_valid_o(xv), .xfer_o(xf), .irq_o(irq));
    iec_cpu_model i_cpu (.ref_clk_i(clk), .rst_b_i(rst_b), .int_i(intr),
        .ack_dly_i(ack_dly), .svc_len_i(svc_len), .cpu_ack_o(cpu_ack),
        .cpu_lvl_o(cpu_lvl));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        @(posedge clk);
        while (ack !== 1'b1 && k++ < 60)
            @(posedge clk);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
        check("ack", 32'(ack), 32'h0000_0001);
    endtask : bus
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
        input string nm);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, rd, e);
    endtask : rchk
    function automatic logic [31:0] mk(input logic [3:0] l,
        input logic x, input logic [2:0] c);
        return 32'(l) | (32'h1 << SC_EN_BIT) | (32'(x) << SC_XFER_BIT)
            | (32'(c) << SC_CH_LSB);
    endfunction : mk
    function automatic logic [11:0] sa(input int i);
        return OFS_SRC_CTRL + 12'(4 * i);
    endfunction : sa
    function automatic logic [11:0] ca(input int c, input int o);
        return OFS_CH_BASE + 12'(CH_STRIDE * c + o);
    endfunction : ca
    task automatic pulse(input logic [NUM_SRC-1:0] m);
        @(posedge clk);
        src_req <= m;
        t0 = cyc_n;
        @(posedge clk);
        src_req <= '0;
    endtask : pulse
    task automatic wreq(input logic [8:0] v, input logic [3:0] l);
        int k = 0;
        while (intr.req !== 1'b1 && k++ < 400)
            @(posedge clk);
        lat = cyc_n - t0;
        check("req", 32'(intr.req), 32'h0000_0001);
        check("vec", 32'(intr.vec), 32'(v));
        check("lvl", 32'(intr.lvl), 32'(l));
        while (intr.req === 1'b1 && k++ < 800)
            @(posedge clk);
    endtask : wreq
    task automatic wnone(input int n);
        logic seen = 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            seen = seen | (intr.req !== 1'b0);
        end
        check("quiet", 32'(seen), 32'h0000_0000);
    endtask : wnone
    task automatic wxf();
        int k = 0;
        while (xv !== 1'b1 && k++ < 20)
            @(posedge clk);
        check("xfer", 32'(xv), 32'h0000_0001);
    endtask : wxf
    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rchk(sa(5), 32'h0000_0000, "src_rst");
        rchk(ca(3, 0), 32'h0000_0000, "ch_rst");
        rchk(12'h200, 32'h0000_0000, "unmapped");
        bus(1'b1, OFS_MASK, 32'h0000_0001);
        for (int i = 0; i < NUM_SRC; i++)
        begin
            ack_dly <= 8'(i % 3 * 6);
            bus(1'b1, sa(i), mk(4'(1 + i % 15), 1'b0, 3'h0));
            pulse(NUM_SRC'(1) << i);
            wreq({TRAPNUM_SRC0 + 7'(i), 2'b00}, 4'(1 + i % 15));
            check("lat_lo", 32'(lat >= RESP_MIN_CYC), 32'h1);
            check("lat_hi", 32'(lat <= RESP_MAX_CYC), 32'h1);
            rchk(sa(i), mk(4'(1 + i % 15), 1'b0, 3'h0), "flag");
        end
        bus(1'b1, sa(3), mk(4'h5, 1'b0, 3'h0));
        bus(1'b1, sa(4), mk(4'h9, 1'b0, 3'h0));
        bus(1'b1, sa(7), mk(4'h5, 1'b0, 3'h0));
        pulse(NUM_SRC'(24'h00_00D8));
        wreq(9'h050, 4'h9);
        wreq(9'h058, 4'h7);
        wreq(9'h04C, 4'h5);
        wreq(9'h05C, 4'h5);
        svc_len <= 8'hC8;
        bus(1'b1, sa(9), mk(4'h8, 1'b0, 3'h0));
        pulse(NUM_SRC'(1) << 9);
        wreq(9'h064, 4'h8);
        pulse(NUM_SRC'(1) << 8);
        svc_len <= 8'h02;
        wreq(9'h060, 4'h9);
        check("preempt", 32'(lat < 100), 32'h1);
        bus(1'b1, sa(9), mk(4'h9, 1'b0, 3'h0));
        pulse(NUM_SRC'(1) << 9);
        wreq(9'h064, 4'h9);
        bus(1'b1, sa(2), 32'h0000_0009);
        pulse(NUM_SRC'(1) << 2);
        wnone(60);
        rchk(sa(2), 32'h0000_0089, "pend");
        bus(1'b1, sa(2), 32'h0000_0009);
        rchk(sa(2), 32'h0000_0009, "swclr");
        bus(1'b1, sa(2), mk(4'h9, 1'b0, 3'h0) | 32'h0000_0080);
        wreq(9'h048, 4'h9);
        @(posedge clk);
        {sw_trap, sw_num} <= {1'b1, 7'h30};
        @(posedge clk);
        sw_trap <= 1'b0;
        wreq(9'h0C0, 4'h0);
        for (int b = 0; b < NUM_HWT; b++)
        begin
            @(posedge clk);
            hw_trap <= 4'(1 << b);
            @(posedge clk);
            hw_trap <= 4'h0;
            wreq({tn[b], 2'b00}, LVL_TRAP);
            rchk(OFS_TRAP_FLAGS, 32'(1 << b), "tflag");
            if (b == 0)
                pulse(NUM_SRC'(1) << 5);
            if (b == 0)
                wnone(60);
            bus(1'b1, OFS_TRAP_FLAGS, 32'(1 << b));
            if (b == 0)
                wreq(9'h054, 4'h6);
        end
        check("irq_mask", 32'(irq), 32'h0000_0000);
        rchk(OFS_STATUS, 32'h0000_0002, "status");
        bus(1'b1, OFS_STATUS, 32'h0000_0003);
        for (int c = 0; c < NUM_CH; c++)
        begin
            cw = 32'h2 | 32'((c & 1) << CC_WORD_BIT)
                | 32'((c >> 1 & 1) << CC_INCDST_BIT);
            st = 1 + (c & 1);
            bus(1'b1, ca(c, CH_OFS_CTRL), cw);
            bus(1'b1, ca(c, CH_OFS_SRC), 32'h1000 + c);
            bus(1'b1, ca(c, CH_OFS_DST), 32'h2000 + c);
            bus(1'b1, sa(10), mk(4'h1, 1'b1, 3'(c)));
            pulse(NUM_SRC'(1) << 10);
            wxf();
            check("src", 32'(xf.src), 32'h1000 + c);
            check("word", 32'(xf.word), 32'(c & 1));
            wnone(40);
            pulse(NUM_SRC'(1) << 10);
            wxf();
            check("src2", 32'(xf.src), 32'h1000 + c + (c & 2 ? 0 : st));
            check("dst2", 32'(xf.dst), 32'h2000 + c + (c & 2 ? st : 0));
            rchk(ca(c, 0), cw & 32'hFFFF_FF00, "count");
            wreq(9'h068, 4'h1);
            check("irq", 32'(irq), 32'h0000_0001);
            bus(1'b1, OFS_STATUS, 32'h0000_0001);
            @(posedge clk);
            check("irq_clr", 32'(irq), 32'h0000_0000);
        end
        cw = 32'h3 | (32'h1 << CC_CONT_BIT);
        bus(1'b1, ca(7, 0), cw);
        bus(1'b1, sa(10), mk(4'h1, 1'b1, 3'h7));
        repeat (2)
        begin
            pulse(NUM_SRC'(1) << 10);
            wxf();
        end
        rchk(ca(7, 0), cw, "cont");
        wnone(40);
        final_report();
    end
endmodule : testbench
